// ===== verilog/dsa_pkg.sv
// package of constants and carriers for the data-space access decoder
package dsa_pkg;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned MEM_BYTES      = 4096;
  localparam int unsigned MEM_WORDS      = MEM_BYTES / 2;
  localparam int unsigned WIDX_W         = 11;
  localparam logic [15:0] MEM_BASE       = 16'h1000;
  localparam logic [15:0] MEM_LAST       = 16'h1fff;
  localparam logic [15:0] CTRL_LAST      = 16'h0fff;
  localparam logic [15:0] NEAR_LAST      = 16'h1fff;
  localparam int unsigned NEAR_FIELD_W   = 13;
  localparam int unsigned WINDOW_BIT     = 15;
  localparam logic [15:0] STEP_BYTE      = 16'h0001;
  localparam logic [15:0] STEP_WORD      = 16'h0002;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  localparam logic [7:0]  ONES_BYTE      = 8'hff;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;
  localparam int unsigned SIGN_BIT       = 7;

  // working register update kinds
  typedef enum logic [3:0] {
    DSA_WB_NONE  = 4'h1,
    DSA_WB_BYTE  = 4'h2,
    DSA_WB_SIGN  = 4'h4,
    DSA_WB_ZERO  = 4'h8
  } dsa_wb_e;

  // one read or write request from the core
  typedef struct packed {
    logic        valid;
    logic        is_byte;
    logic        post_inc;
    logic [15:0] byte_pointer_value;
    logic [15:0] wdata;
  } dsa_req_s;

  // address error report
  typedef struct packed {
    logic fault;
    logic was_write;
    logic [15:0] addr;
  } dsa_err_s;
endpackage : dsa_pkg

// ===== verilog/dsa_word_store.sv
// implemented data memory with separate byte-lane write strobes
`timescale 1ns/1ps
`default_nettype none
module dsa_word_store
  import dsa_pkg::*;
(
  input  wire logic              clk_i,   // core clock
  input  wire logic [WIDX_W-1:0] raddr_i, // read word index
  output logic      [15:0]       rdata_o, // read word
  input  wire logic [WIDX_W-1:0] waddr_i, // write word index
  input  wire logic [1:0]        wbe_i,   // lane strobes
  input  wire logic [15:0]       wdata_i  // write word
);
  logic [15:0] mem [MEM_WORDS];

  // combinational read of the whole word
  assign rdata_o = mem[raddr_i];

  // each lane written on its own strobe
  always_ff @(posedge clk_i)
  begin
    if (wbe_i[0])
    begin
      mem[waddr_i][7:0] <= wdata_i[7:0];
    end
    if (wbe_i[1])
    begin
      mem[waddr_i][15:8] <= wdata_i[15:8];
    end
  end
endmodule // dsa_word_store
`default_nettype wire

// ===== verilog/dsa_top.sv
// data-space access decoder: lanes, decode, misalignment trap
// What this block does
// - read and write addresses come from separate address units
// - effective addresses are 16-bit byte addresses, 64 Kbytes in total
// - top address bit clear is data memory, set is program window
// - at most 4 Kbytes memory; reads outside implemented area return zero
// - low byte at even address, high byte at next odd address
// - post-increment advances pointer by one for bytes, two for words
// - byte read fetches whole word, low address bit picks byte
// - shared word decode, separate byte-lane write strobes
// - word access with odd byte_pointer_value is misaligned, raises address error; a misaligned write is not done
// - misaligned read completes, misaligned write suppressed, then trap
// - byte load writes working register low byte only
// - sign widen copies bit 7 into the high byte
// - zero widen clears the high byte
// - lowest 4 Kbytes decode as control register space
// - unused control register addresses read as zero
// - 8-Kbyte near region reachable for reads through 13-bit absolute field
// - whole space reachable by 16-bit direct or pointer addresses
`timescale 1ns/1ps
`default_nettype none
module dsa_top
  import dsa_pkg::*;
(
  input  wire logic        clk_i,        // core clock, 20 MHz
  input  wire logic        srst_i,       // sync reset, active high
  input  wire dsa_req_s    rd_req_i,     // read address unit request
  input  wire dsa_req_s    wr_req_i,     // write address unit request
  input  wire logic        ctrl_rhit_i,  // control reg implemented at read addr
  input  wire logic [15:0] ctrl_rdata_i, // control reg read word
  input  wire logic [12:0] near_field_i, // absolute 13-bit direct field
  input  wire logic        near_sel_i,   // use near field as read address
  input  wire dsa_wb_e     wb_op_i,      // working register update kind
  input  wire logic [15:0] wreg_i,       // current working register value
  output logic [15:0]      rdata_o,      // read data to core
  output logic [15:0]      wreg_o,       // updated working register
  output logic [15:0]      rd_ptr_o,     // post-modified read pointer
  output logic [15:0]      wr_ptr_o,     // post-modified write pointer
  output logic             window_o,     // read hit program window
  output logic [15:0]      window_addr_o,// window-relative address
  output logic [1:0]       ctrl_wbe_o,   // control reg lane strobes
  output logic [15:0]      ctrl_waddr_o, // control reg write address
  output logic [15:0]      ctrl_wdata_o, // control reg write data
  output dsa_err_s         err_o         // address error pulse
);
  // region decode shared by both address units
  function automatic logic in_ctrl(input logic [15:0] a);
    return a <= CTRL_LAST;
  endfunction

  function automatic logic in_mem(input logic [15:0] a);
    return (a >= MEM_BASE) && (a <= MEM_LAST);
  endfunction

  function automatic logic misaligned(input dsa_req_s r);
    return r.valid && !r.is_byte && r.byte_pointer_value[0];
  endfunction

  function automatic logic [15:0] post_mod(input dsa_req_s r);
    if (!r.post_inc)
    begin
      return r.byte_pointer_value;
    end
    return r.byte_pointer_value + (r.is_byte ? STEP_BYTE : STEP_WORD);
  endfunction

  function automatic logic [WIDX_W-1:0] widx(input logic [15:0] a);
    logic [15:0] off;
    off = a - MEM_BASE;
    return off[WIDX_W:1];
  endfunction

  // all registered state of the block
  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] wreg;
    logic [15:0] rd_ptr;
    logic [15:0] wr_ptr;
    logic        window;
    logic [15:0] window_addr;
    dsa_err_s    err;
  } dsa_state_s;

  dsa_state_s  st;
  dsa_state_s  next_st;
  logic [15:0] rd_addr;
  logic [15:0] mem_rword;
  logic [15:0] raw_word;
  logic [7:0]  sel_byte;
  logic [15:0] rd_value;
  logic        rd_bad;
  logic        wr_bad;
  logic [1:0]  lanes;
  logic [1:0]  mem_wbe;
  logic [15:0] lane_data;

  // read address: 13-bit near field or full 16-bit pointer
  assign rd_addr = near_sel_i ? {3'h0, near_field_i}
                              : rd_req_i.byte_pointer_value;

  // misalignment on each address unit independently
  assign rd_bad = misaligned(rd_req_i);
  assign wr_bad = misaligned(wr_req_i);

  // write lanes: byte picks one side, word both
  always_comb
  begin
    lanes     = 2'h0;
    lane_data = wr_req_i.wdata;
    if (wr_req_i.valid && !wr_bad)
    begin
      if (wr_req_i.is_byte)
      begin
        lanes     = wr_req_i.byte_pointer_value[0] ? 2'h2 : 2'h1;
        lane_data = {wr_req_i.wdata[7:0], wr_req_i.wdata[7:0]};
      end
      else
      begin
        lanes = 2'h3;
      end
    end
  end

  // route strobes; other regions drop the write
  assign mem_wbe = in_mem(wr_req_i.byte_pointer_value) ? lanes : 2'h0;
  always_comb
  begin
    ctrl_wbe_o   = in_ctrl(wr_req_i.byte_pointer_value) ? lanes : 2'h0;
    ctrl_waddr_o = wr_req_i.byte_pointer_value;
    ctrl_wdata_o = lane_data;
  end

  dsa_word_store u_store (
    .clk_i   (clk_i),
    .raddr_i (widx(rd_addr)),
    .rdata_o (mem_rword),
    .waddr_i (widx(wr_req_i.byte_pointer_value)),
    .wbe_i   (mem_wbe),
    .wdata_i (lane_data)
  );

  // whole word fetched, zero outside implemented areas
  always_comb
  begin
    raw_word = ZERO_WORD;
    if (rd_addr[WINDOW_BIT])
    begin
      raw_word = ZERO_WORD;
    end
    else if (in_ctrl(rd_addr))
    begin
      raw_word = ctrl_rhit_i ? ctrl_rdata_i : ZERO_WORD;
    end
    else if (in_mem(rd_addr))
    begin
      raw_word = mem_rword;
    end
    sel_byte = rd_addr[0] ? raw_word[15:8] : raw_word[7:0];
    rd_value = rd_req_i.is_byte ? {ZERO_BYTE, sel_byte} : raw_word;
  end

  // next state: read data, working register, pointers, trap
  always_comb
  begin
    next_st             = st;
    next_st.err         = '0;
    next_st.rdata       = rd_req_i.valid ? rd_value : st.rdata;
    next_st.window      = rd_req_i.valid && rd_addr[WINDOW_BIT];
    next_st.window_addr = {1'b0, rd_addr[14:0]};
    next_st.rd_ptr      = post_mod(rd_req_i);
    next_st.wr_ptr      = post_mod(wr_req_i);
    case (wb_op_i)
      DSA_WB_BYTE: next_st.wreg = {wreg_i[15:8], rd_value[7:0]};
      DSA_WB_SIGN: next_st.wreg = {wreg_i[SIGN_BIT] ? ONES_BYTE : ZERO_BYTE,
                                   wreg_i[7:0]};
      DSA_WB_ZERO: next_st.wreg = {ZERO_BYTE, wreg_i[7:0]};
      DSA_WB_NONE: next_st.wreg = rd_req_i.valid ? rd_value : wreg_i;
      default:     next_st.wreg = wreg_i;
    endcase
    if (wr_bad)
    begin
      next_st.err = '{fault: 1'b1, was_write: 1'b1,
                      addr: wr_req_i.byte_pointer_value};
    end
    else if (rd_bad)
    begin
      next_st.err = '{fault: 1'b1, was_write: 1'b0,
                      addr: rd_req_i.byte_pointer_value};
    end
    if (srst_i)
    begin
      next_st = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  assign rdata_o       = st.rdata;
  assign wreg_o        = st.wreg;
  assign rd_ptr_o      = st.rd_ptr;
  assign wr_ptr_o      = st.wr_ptr;
  assign window_o      = st.window;
  assign window_addr_o = st.window_addr;
  assign err_o         = st.err;

  // misaligned word write never reaches a strobe
  property p_no_bad_write;
    @(posedge clk_i) disable iff (srst_i)
      wr_bad |-> (mem_wbe == 2'h0) && (ctrl_wbe_o == 2'h0);
  endproperty
  a_no_bad_write: assert property (p_no_bad_write)
    else $error("misaligned write reached a strobe");

  // trap raised one cycle after misalignment
  property p_trap;
    @(posedge clk_i) disable iff (srst_i)
      (rd_bad || wr_bad) |=> err_o.fault && (err_o.was_write == $past(wr_bad));
  endproperty
  a_trap: assert property (p_trap)
    else $error("address error not raised");

  // trap is one cycle unless cause repeats
  property p_pulse;
    @(posedge clk_i) disable iff (srst_i)
      (err_o.fault && !$past(rd_bad || wr_bad, 1)) |-> 1'b0;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("address error without cause");

  // byte write strobes exactly one lane
  property p_byte_lane;
    @(posedge clk_i) disable iff (srst_i)
      (wr_req_i.valid && wr_req_i.is_byte && in_mem(wr_req_i.byte_pointer_value))
        |-> mem_wbe == (wr_req_i.byte_pointer_value[0] ? 2'h2 : 2'h1);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte write lane wrong");

  // window and unmapped reads return zero
  property p_zero_read;
    @(posedge clk_i) disable iff (srst_i)
      (rd_req_i.valid && !in_mem(rd_addr) && !(in_ctrl(rd_addr) && ctrl_rhit_i))
        |=> rdata_o == ZERO_WORD;
  endproperty
  a_zero_read: assert property (p_zero_read)
    else $error("unimplemented read not zero");

  // pointer step
  property p_step;
    @(posedge clk_i) disable iff (srst_i)
      rd_req_i.post_inc |=> rd_ptr_o ==
        $past(rd_req_i.byte_pointer_value) + ($past(rd_req_i.is_byte) ? STEP_BYTE : STEP_WORD);
  endproperty
  a_step: assert property (p_step)
    else $error("post increment step wrong");

  // byte load keeps high byte
  property p_byte_load;
    @(posedge clk_i) disable iff (srst_i)
      (wb_op_i == DSA_WB_BYTE) |=> wreg_o[15:8] == $past(wreg_i[15:8]);
  endproperty
  a_byte_load: assert property (p_byte_load)
    else $error("byte load touched high byte");

  // sign widen copies bit seven
  property p_sign;
    @(posedge clk_i) disable iff (srst_i)
      (wb_op_i == DSA_WB_SIGN) |=> wreg_o[15:8] == {8{$past(wreg_i[7])}};
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign widen wrong");

  // zero widen clears high byte
  property p_zero;
    @(posedge clk_i) disable iff (srst_i)
      (wb_op_i == DSA_WB_ZERO) |=> wreg_o[15:8] == ZERO_BYTE;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero widen wrong");

  // writes outside both regions strobe nothing
  property p_drop;
    @(posedge clk_i) disable iff (srst_i)
      (!in_mem(wr_req_i.byte_pointer_value) && !in_ctrl(wr_req_i.byte_pointer_value))
        |-> (mem_wbe == 2'h0) && (ctrl_wbe_o == 2'h0);
  endproperty
  a_drop: assert property (p_drop)
    else $error("out of range write not dropped");

  // word write strobes both lanes
  property p_word_lanes;
    @(posedge clk_i) disable iff (srst_i)
      (wr_req_i.valid && !wr_req_i.is_byte && !wr_bad && in_mem(wr_req_i.byte_pointer_value))
        |-> mem_wbe == 2'h3;
  endproperty
  a_word_lanes: assert property (p_word_lanes)
    else $error("word write lanes wrong");

  // window flag follows the top address bit
  property p_window;
    @(posedge clk_i) disable iff (srst_i)
      rd_req_i.valid |=> window_o == $past(rd_addr[WINDOW_BIT]);
  endproperty
  a_window: assert property (p_window)
    else $error("window flag wrong");

  // byte read lands on the low lane, high lane zero
  property p_byte_read;
    @(posedge clk_i) disable iff (srst_i)
      (rd_req_i.valid && rd_req_i.is_byte) |=> rdata_o[15:8] == ZERO_BYTE;
  endproperty
  a_byte_read: assert property (p_byte_read)
    else $error("byte read high lane not zero");

  // implemented control register word passes through
  property p_ctrl_read;
    @(posedge clk_i) disable iff (srst_i)
      (rd_req_i.valid && !rd_req_i.is_byte && in_ctrl(rd_addr) && ctrl_rhit_i)
        |=> rdata_o == $past(ctrl_rdata_i);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control register read wrong");

  // write pointer step
  property p_wr_step;
    @(posedge clk_i) disable iff (srst_i)
      wr_req_i.post_inc |=> wr_ptr_o ==
        $past(wr_req_i.byte_pointer_value) + ($past(wr_req_i.is_byte) ? STEP_BYTE : STEP_WORD);
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("write pointer step wrong");

  // read fault reports the read side and its address
  property p_err_read;
    @(posedge clk_i) disable iff (srst_i)
      (rd_bad && !wr_bad)
        |=> !err_o.was_write && (err_o.addr == $past(rd_req_i.byte_pointer_value));
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("read fault report wrong");
endmodule // dsa_top
`default_nettype wire

// ===== test/dsa_ctrl_model.sv
// control-register stub standing where peripheral registers sit
`timescale 1ns/1ps
`default_nettype none
module dsa_ctrl_model
  import dsa_pkg::*;
(
  input  wire logic        clk_i,   // core clock
  input  wire logic [15:0] raddr_i, // read byte address
  output logic             rhit_o,  // register exists at raddr_i
  output logic [15:0]      rdata_o, // register word
  input  wire logic [1:0]  wbe_i,   // lane strobes
  input  wire logic [15:0] waddr_i, // write byte address
  input  wire logic [15:0] wdata_i  // write word
);
  localparam logic [15:0] REG_ADDR = 16'h0800;
  logic [15:0] reg_q = 16'h0000;
  logic [15:0] junk  = 16'h5aa5;

  // only one implemented word; other places drive a changing pattern
  assign rhit_o  = (raddr_i[15:1] == REG_ADDR[15:1]);
  assign rdata_o = rhit_o ? reg_q : junk;

  // lane-wise update, pattern churn
  always_ff @(posedge clk_i)
  begin
    junk <= ~junk + 16'h1357;
    if (waddr_i[15:1] == REG_ADDR[15:1] && wbe_i[0]) reg_q[7:0] <= wdata_i[7:0];
    if (waddr_i[15:1] == REG_ADDR[15:1] && wbe_i[1]) reg_q[15:8] <= wdata_i[15:8];
  end
endmodule // dsa_ctrl_model
`default_nettype wire

// ===== test/test_data_space_access_decode.sv
// self-checking bench for the data-space access decoder
`timescale 1ns/1ps
`default_nettype none
module test_data_space_access_decode;
  import dsa_pkg::*;
  logic        clk_i;
  logic        srst_i;
  dsa_req_s    rd_req;
  dsa_req_s    wr_req;
  logic        c_hit;
  logic [15:0] c_rdata;
  logic [12:0] near_field;
  logic        near_sel;
  dsa_wb_e     wb_op;
  logic [15:0] wreg;
  logic [15:0] rdata_o;
  logic [15:0] wreg_o;
  logic [15:0] rd_ptr_o;
  logic [15:0] wr_ptr_o;
  logic        window_o;
  logic [15:0] window_addr_o;
  logic [1:0]  ctrl_wbe_o;
  logic [15:0] ctrl_waddr_o;
  logic [15:0] ctrl_wdata_o;
  dsa_err_s    err_o;
  int          fail_count;
  int          n_tests;

  dsa_top DUT (.clk_i(clk_i), .srst_i(srst_i), .rd_req_i(rd_req), .wr_req_i(wr_req),
    .ctrl_rhit_i(c_hit), .ctrl_rdata_i(c_rdata), .near_field_i(near_field),
    .near_sel_i(near_sel), .wb_op_i(wb_op), .wreg_i(wreg), .rdata_o(rdata_o),
    .wreg_o(wreg_o), .rd_ptr_o(rd_ptr_o), .wr_ptr_o(wr_ptr_o), .window_o(window_o),
    .window_addr_o(window_addr_o), .ctrl_wbe_o(ctrl_wbe_o), .ctrl_waddr_o(ctrl_waddr_o),
    .ctrl_wdata_o(ctrl_wdata_o), .err_o(err_o));

  dsa_ctrl_model u_ctrl (.clk_i(clk_i), .rhit_o(c_hit),
    .raddr_i(near_sel ? {3'h0, near_field} : rd_req.byte_pointer_value),
    .rdata_o(c_rdata), .wbe_i(ctrl_wbe_o), .waddr_i(ctrl_waddr_o), .wdata_i(ctrl_wdata_o));

  // clock generation
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one read and/or write taken at the next edge, left standing until the next call
  task automatic go(input logic rv, input logic [15:0] ra, input logic rb,
                    input logic wv, input logic [15:0] wa, input logic wb, input logic [15:0] wd);
    rd_req.valid = rv;
    rd_req.byte_pointer_value = ra;
    rd_req.is_byte = rb;
    wr_req.valid = wv;
    wr_req.byte_pointer_value = wa;
    wr_req.is_byte = wb;
    wr_req.wdata = wd;
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic b, input logic [15:0] exp);
    go(1'b1, a, b, 1'b0, 16'h0000, 1'b0, 16'h0000);
    chk(rdata_o, exp);
  endtask

  task automatic t_lanes;
    go(1'b0, 16'h0000, 1'b0, 1'b1, 16'h1002, 1'b0, 16'h1234);
    rd(16'h1002, 1'b0, 16'h1234);
    chk(rd_ptr_o, 16'h1004);
    rd(16'h1002, 1'b1, 16'h0034);
    chk(rd_ptr_o, 16'h1003);
    rd(16'h1003, 1'b1, 16'h0012);
    go(1'b0, 16'h0000, 1'b0, 1'b1, 16'h1003, 1'b1, 16'h00ab);
    chk(wr_ptr_o, 16'h1004);
    rd(16'h1002, 1'b0, 16'hab34);
  endtask

  task automatic t_misalign;
    go(1'b0, 16'h0000, 1'b0, 1'b1, 16'h1004, 1'b0, 16'h5678);
    go(1'b0, 16'h0000, 1'b0, 1'b1, 16'h1005, 1'b0, 16'hdead);
    chk({14'h0, err_o.fault, err_o.was_write}, 16'h0003);
    chk(err_o.addr, 16'h1005);
    rd(16'h1004, 1'b0, 16'h5678);
    chk({15'h0, err_o.fault}, 16'h0000);
    go(1'b1, 16'h1003, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0000);
    chk({14'h0, err_o.fault, err_o.was_write}, 16'h0002);
  endtask

  task automatic t_map;
    rd(16'h8abc, 1'b0, 16'h0000);
    chk({15'h0, window_o}, 16'h0001);
    chk(window_addr_o, 16'h0abc);
    rd(16'h2000, 1'b0, 16'h0000);
    rd(16'h0100, 1'b0, 16'h0000);
    rd_req.valid = 1'b0;
    wr_req.byte_pointer_value = 16'h3002;
    wr_req.wdata = 16'h1111;
    wr_req.valid = 1'b1;
    #1;
    chk({14'h0, ctrl_wbe_o}, 16'h0000);
    @(posedge clk_i);
    #1;
    wr_req.byte_pointer_value = 16'h0800;
    wr_req.wdata = 16'hbeef;
    #1;
    chk({14'h0, ctrl_wbe_o}, 16'h0003);
    @(posedge clk_i);
    #1;
    chk({15'h0, err_o.fault}, 16'h0000);
    rd(16'h0800, 1'b0, 16'hbeef);
    rd(16'h1002, 1'b0, 16'hab34);
  endtask

  task automatic t_near_wb;
    near_sel = 1'b1;
    near_field = 13'h1002;
    rd(16'h0000, 1'b0, 16'hab34);
    near_sel = 1'b0;
    wb_op = DSA_WB_BYTE;
    wreg = 16'hff00;
    go(1'b1, 16'h1003, 1'b1, 1'b1, 16'h1006, 1'b0, 16'h4321);
    chk(wreg_o, 16'hffab);
    rd(16'h1006, 1'b0, 16'h4321);
    wb_op = DSA_WB_SIGN;
    wreg = 16'h0080;
    go(1'b0, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0000);
    chk(wreg_o, 16'hff80);
    wb_op = DSA_WB_ZERO;
    wreg = 16'h12f0;
    go(1'b0, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0000);
    chk(wreg_o, 16'h00f0);
    wb_op = DSA_WB_NONE;
    rd_req.post_inc = 1'b0;
    rd(16'hfffe, 1'b0, 16'h0000);
    chk(rd_ptr_o, 16'hfffe);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #(400 * 50);
    fail_count++;
    end_sim();
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    n_tests = 0;
    srst_i = 1'b1;
    rd_req = '{post_inc: 1'b1, default: '0};
    wr_req = '{post_inc: 1'b1, default: '0};
    near_field = 13'h0000;
    near_sel = 1'b0;
    wb_op = DSA_WB_NONE;
    wreg = 16'h0000;
    repeat (4) @(posedge clk_i);
    #1;
    chk(rdata_o, 16'h0000);
    srst_i = 1'b0;
    t_lanes();
    t_misalign();
    t_map();
    t_near_wb();
    end_sim();
  end
endmodule // test_data_space_access_decode
`default_nettype wire
